//--- hdl/tw_cfg.svh
`ifndef TW_CFG_SVH
`define TW_CFG_SVH
// register byte addresses
`define TW_A_BUF 5'h00
`define TW_A_CON1 5'h04
`define TW_A_CON3 5'h08
`define TW_A_STAT 5'h0C
`define TW_A_SADR 5'h10
`define TW_A_CMD 5'h14
`define TW_A_DIV 5'h18
// control primary fields
`define TW_C1_WCOL 7
`define TW_C1_OV 6
`define TW_C1_EN 5
`define TW_C1_MODE 3:0
`define TW_MODE_SLV 4'h6
`define TW_MODE_MST 4'h8
// control tertiary and status fields
`define TW_C3_CFG 6:0
`define TW_ST_CFG 7:6
// command register fields
`define TW_CM_STA 0
`define TW_CM_STP 1
`define TW_CM_WR 2
`define TW_CM_RD 3
`define TW_CM_ACKDT 4
`define TW_CM_ARBL 7
// byte framing
`define TW_ADR_F 7:1
`define TW_RW_BIT 0
`define TW_MSB 7
`define TW_ACK_BIT 4'h8
`define TW_END_BIT 4'h9
// reset values
`define TW_DIV_RST 8'h3E
`define TW_SYNC_RST 3'h7
`endif

//--- hdl/tw_pkg.sv
package tw_pkg;
   typedef enum logic [1:0] {
      M_IDLE = 2'b00,
      M_STA = 2'b01,
      M_STP = 2'b10,
      M_BIT = 2'b11
   } tw_mst_t;
   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_ADR = 2'b01,
      S_RX = 2'b10,
      S_TX = 2'b11
   } tw_slv_t;
   typedef struct packed {
      logic [2:0] scl_sy;
      logic [2:0] sda_sy;
      logic scl_lo;
      logic busy;
      logic wreq;
      logic [31:0] rdata;
      logic [7:0] txbuf;
      logic [7:0] rxbuf;
      logic [7:0] sadr;
      logic [7:0] div;
      logic [7:0] qcnt;
      logic en;
      logic [3:0] mode;
      logic wcol;
      logic ov;
      logic bf;
      logic da;
      logic stp;
      logic sta;
      logic rw;
      logic acktim;
      logic [6:0] con3;
      logic [1:0] stat_hi;
      tw_mst_t mst;
      logic [1:0] ph;
      logic [3:0] mbit;
      logic mrd;
      logic mack;
      logic own;
      logic ackstat;
      logic arbl;
      logic m_sda_lo;
      logic m_scl_lo;
      logic [7:0] mshf;
      tw_slv_t slv;
      logic [3:0] sbit;
      logic [7:0] sshf;
      logic s_sda_lo;
      logic s_scl_lo;
      logic s_rel;
      logic txv;
      logic lvl;
      logic scl_oe;
      logic sda_oe;
   } tw_st_t;
endpackage

//--- hdl/tw_core.sv
// Contract
// - both lines are open drain: pull low for zero, release for one
// - start is sda falling while scl high; all parties detect it
// - stop is sda rising while scl high; all parties detect it
// - data changes sda only while scl is low
// - master opens with start, address bits, then direction bit
// - direction bit one means read, zero means write
// - every byte is shifted most significant bit first
// - matching slave pulls sda low on ack; others leave it released
// - after address ack roles follow the direction bit
// - in a write the slave acks every byte it receives; here a byte arriving while bf is still set is dropped and not acked
// - in a read the master answers every byte with an ack bit
// - receiving master ends with stop in place of last ack
// - repeated start may replace stop or last ack to keep the bus
// - single write, single read and combined messages are supported
// - addressed slave may hold scl low until it can continue
// - master releasing scl waits while scl is still held low
// - master tracks start and stop and waits for idle bus
// - transmitter seeing sda mismatch loses and stops driving sda
// - losing master also releases scl and may wait for stop
// - transmitter without mismatch continues undisturbed
// - lower address wins; equal addresses arbitrate through data
// - slave transmitter also withdraws on sda mismatch
// - nine clocks per byte; sender releases sda for the ack clock
// - stop valid only after an scl low since the start
//
// The implementer's own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`include "tw_cfg.svh"
module tw_core
   import tw_pkg::*;
(
   // system
   input wire logic clock,
   input wire logic rstn,
   // avalon-mm slave
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // two-wire bus
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe
);
   tw_st_t r;
   tw_st_t n;
   logic scl_h;
   logic sda_h;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   logic tick;
   logic m_on;
   logic s_on;
   logic wr_go;

   function automatic logic [31:0] word(input logic [7:0] b);
      return {24'h000000, b};
   endfunction

   // stage 0 is read only by stage 1; stages 1 and 2 feed all detection
   assign scl_h = r.scl_sy[1];
   assign sda_h = r.sda_sy[1];
   assign scl_rise = r.scl_sy[1] && !r.scl_sy[2];
   assign scl_fall = !r.scl_sy[1] && r.scl_sy[2];
   assign start_c = scl_h && r.scl_sy[2] && !sda_h && r.sda_sy[2];
   // a low-high blip on sda with scl high counts as stop only once scl has been low since the start
   assign stop_c = scl_h && r.scl_sy[2] && sda_h && !r.sda_sy[2] && r.scl_lo;
   assign tick = (r.qcnt == r.div);
   assign m_on = r.en && (r.mode == `TW_MODE_MST);
   assign s_on = r.en && (r.mode == `TW_MODE_SLV);
   assign wr_go = write && !r.wreq;

   assign readdata = r.rdata;
   assign waitrequest = r.wreq;
   assign scl_o = r.lvl;
   assign sda_o = r.lvl;
   assign scl_oe = r.scl_oe;
   assign sda_oe = r.sda_oe;

   always_comb begin
      logic lose;
      lose = 1'b0;
      n = r;
      n.scl_sy = {r.scl_sy[1:0], scl_i};
      n.sda_sy = {r.sda_sy[1:0], sda_i};
      n.qcnt = tick ? 8'h00 : r.qcnt + 8'h01;

      // bus watcher
      if (!scl_h) begin
         n.scl_lo = 1'b1;
      end
      if (start_c) begin
         n.busy = 1'b1;
         n.scl_lo = 1'b0;
         n.sta = 1'b1;
         n.stp = 1'b0;
      end
      if (stop_c) begin
         n.busy = 1'b0;
         n.stp = 1'b1;
         n.sta = 1'b0;
      end

      // register bus: one wait cycle, read data prepared with it
      n.wreq = !((read || write) && r.wreq);
      if ((read || write) && r.wreq) begin
         case (address)
            `TW_A_BUF: n.rdata = word(r.rxbuf);
            `TW_A_CON1: n.rdata = word({r.wcol, r.ov, r.en, 1'b0, r.mode});
            `TW_A_CON3: n.rdata = word({r.acktim, r.con3});
            `TW_A_STAT: n.rdata = word({r.stat_hi, r.da, r.stp, r.sta, r.rw, 1'b0, r.bf});
            `TW_A_SADR: n.rdata = word(r.sadr);
            `TW_A_CMD: n.rdata = word({r.arbl, r.ackstat, r.mst != M_IDLE, r.mack, 4'h0});
            `TW_A_DIV: n.rdata = word(r.div);
            default: n.rdata = 32'h00000000;
         endcase
      end
      // clears come first so a same-cycle hardware set wins
      if (read && !r.wreq && address == `TW_A_BUF) begin
         n.bf = 1'b0;
      end
      if (wr_go) begin
         case (address)
            `TW_A_BUF: begin
               if (r.mst != M_IDLE || (r.slv == S_TX && !r.s_scl_lo)) begin
                  n.wcol = 1'b1;
               end else begin
                  n.txbuf = writedata[7:0];
                  n.txv = 1'b1;
               end
            end
            `TW_A_CON1: begin
               n.wcol = r.wcol & writedata[`TW_C1_WCOL];
               n.ov = r.ov & writedata[`TW_C1_OV];
               n.en = writedata[`TW_C1_EN];
               n.mode = writedata[`TW_C1_MODE];
            end
            `TW_A_CON3: n.con3 = writedata[`TW_C3_CFG];
            `TW_A_STAT: n.stat_hi = writedata[`TW_ST_CFG];
            `TW_A_SADR: n.sadr = writedata[7:0];
            `TW_A_DIV: n.div = writedata[7:0];
            `TW_A_CMD: begin
               if (writedata[`TW_CM_ARBL]) begin
                  n.arbl = 1'b0;
               end
               n.mack = writedata[`TW_CM_ACKDT];
               if (m_on && r.mst == M_IDLE) begin
                  n.ph = 2'h0;
                  n.mbit = 4'h0;
                  if (writedata[`TW_CM_STA]) begin
                     n.mst = M_STA;
                  end else if (writedata[`TW_CM_STP]) begin
                     n.mst = M_STP;
                  end else if (writedata[`TW_CM_WR]) begin
                     n.mst = M_BIT;
                     n.mrd = 1'b0;
                     n.mshf = r.txbuf;
                  end else if (writedata[`TW_CM_RD]) begin
                     n.mst = M_BIT;
                     n.mrd = 1'b1;
                  end
               end
            end
            default: ;
         endcase
      end

      // master engine, four quarter-bit phases per step
      if (!m_on) begin
         n.mst = M_IDLE;
         n.m_sda_lo = 1'b0;
         n.m_scl_lo = 1'b0;
         n.own = 1'b0;
      end else begin
         case (r.mst)
            M_STA: begin
               case (r.ph)
                  2'h0: begin
                     // a bus we already hold may restart at once
                     if (tick && (!r.busy || r.own)) begin
                        n.m_sda_lo = 1'b0;
                        n.ph = 2'h1;
                     end
                  end
                  2'h1: begin
                     if (tick) begin
                        n.m_scl_lo = 1'b0;
                        n.ph = 2'h2;
                     end
                  end
                  2'h2: begin
                     if (tick && scl_h) begin
                        if (!sda_h) begin
                           lose = 1'b1;
                        end else begin
                           n.m_sda_lo = 1'b1;
                           n.ph = 2'h3;
                        end
                     end
                  end
                  default: begin
                     if (tick) begin
                        n.m_scl_lo = 1'b1;
                        n.own = 1'b1;
                        n.mst = M_IDLE;
                     end
                  end
               endcase
            end
            M_STP: begin
               case (r.ph)
                  2'h0: begin
                     if (tick) begin
                        n.m_sda_lo = 1'b1;
                        n.ph = 2'h1;
                     end
                  end
                  2'h1: begin
                     if (tick) begin
                        n.m_scl_lo = 1'b0;
                        n.ph = 2'h2;
                     end
                  end
                  2'h2: begin
                     if (tick && scl_h) begin
                        n.m_sda_lo = 1'b0;
                        n.ph = 2'h3;
                     end
                  end
                  default: begin
                     if (tick) begin
                        if (!sda_h) begin
                           lose = 1'b1;
                        end else begin
                           n.own = 1'b0;
                           n.mst = M_IDLE;
                        end
                     end
                  end
               endcase
            end
            M_BIT: begin
               case (r.ph)
                  2'h0: begin
                     if (tick) begin
                        // data set while scl held low; sender frees sda on ack clock
                        if (r.mbit == `TW_ACK_BIT) begin
                           n.m_sda_lo = r.mrd && !r.mack;
                        end else begin
                           n.m_sda_lo = !r.mrd && !r.mshf[`TW_MSB];
                        end
                        n.ph = 2'h1;
                     end
                  end
                  2'h1: begin
                     if (tick) begin
                        n.m_scl_lo = 1'b0;
                        n.ph = 2'h2;
                     end
                  end
                  2'h2: begin
                     // a stretched clock holds this phase until scl is seen high
                     if (tick && scl_h) begin
                        if (!r.mrd && r.mbit != `TW_ACK_BIT && !r.m_sda_lo && !sda_h) begin
                           lose = 1'b1;
                        end else if (r.mbit == `TW_ACK_BIT) begin
                           if (!r.mrd) begin
                              n.ackstat = sda_h;
                           end
                           n.ph = 2'h3;
                        end else begin
                           n.mshf = {r.mshf[6:0], sda_h};
                           n.ph = 2'h3;
                        end
                     end
                  end
                  default: begin
                     if (tick) begin
                        n.m_scl_lo = 1'b1;
                        n.ph = 2'h0;
                        if (r.mbit == `TW_ACK_BIT) begin
                           n.mst = M_IDLE;
                           if (r.mrd) begin
                              n.da = 1'b1;
                              if (r.bf) begin
                                 n.ov = 1'b1;
                              end else begin
                                 n.rxbuf = r.mshf;
                                 n.bf = 1'b1;
                              end
                           end
                        end else begin
                           n.mbit = r.mbit + 4'h1;
                        end
                     end
                  end
               endcase
            end
            default: ;
         endcase
      end
      if (lose) begin
         n.m_sda_lo = 1'b0;
         n.m_scl_lo = 1'b0;
         n.own = 1'b0;
         n.arbl = 1'b1;
         n.mst = M_IDLE;
      end

      // slave engine, paced by the bus clock edges
      if (!s_on || stop_c) begin
         n.slv = S_IDLE;
         n.s_sda_lo = 1'b0;
         n.s_scl_lo = 1'b0;
         n.s_rel = 1'b0;
         n.acktim = 1'b0;
      end else if (start_c) begin
         n.slv = S_ADR;
         n.sbit = 4'h0;
         n.s_sda_lo = 1'b0;
         n.s_scl_lo = 1'b0;
         n.s_rel = 1'b0;
      end else if (r.slv != S_IDLE) begin
         if (scl_rise) begin
            if (r.sbit == `TW_ACK_BIT) begin
               n.sbit = `TW_END_BIT;
               if (r.slv == S_TX && sda_h) begin
                  n.slv = S_IDLE;
               end
            end else if (r.sbit != `TW_END_BIT) begin
               n.sbit = r.sbit + 4'h1;
               if (r.slv == S_TX && !r.s_sda_lo && !sda_h) begin
                  n.slv = S_IDLE;
               end else begin
                  n.sshf = {r.sshf[6:0], sda_h};
               end
            end
         end
         if (scl_fall) begin
            case (r.sbit)
               `TW_ACK_BIT: begin
                  case (r.slv)
                     S_ADR: begin
                        if (r.sshf[`TW_ADR_F] == r.sadr[`TW_ADR_F]) begin
                           n.s_sda_lo = 1'b1;
                           n.rw = r.sshf[`TW_RW_BIT];
                           n.rxbuf = r.sshf;
                           n.da = 1'b0;
                           n.acktim = 1'b1;
                        end else begin
                           n.slv = S_IDLE;
                        end
                     end
                     S_RX: begin
                        n.acktim = 1'b1;
                        n.da = 1'b1;
                        // a byte arriving while an unread byte is held is lost and not acknowledged
                        if (r.bf) begin
                           n.ov = 1'b1;
                        end else begin
                           n.rxbuf = r.sshf;
                           n.bf = 1'b1;
                           n.s_sda_lo = 1'b1;
                        end
                     end
                     default: begin
                        n.s_sda_lo = 1'b0;
                        n.acktim = 1'b1;
                     end
                  endcase
               end
               `TW_END_BIT: begin
                  n.sbit = 4'h0;
                  n.acktim = 1'b0;
                  n.s_sda_lo = 1'b0;
                  if (r.slv == S_ADR) begin
                     n.slv = r.rw ? S_TX : S_RX;
                  end
                  if (r.slv == S_TX || (r.slv == S_ADR && r.rw)) begin
                     n.s_scl_lo = 1'b1;
                  end
               end
               default: begin
                  if (r.slv == S_TX) begin
                     n.s_sda_lo = !r.sshf[`TW_MSB];
                  end
               end
            endcase
         end
         // data is put on sda one cycle before scl is let go
         if (r.s_scl_lo && r.txv && !r.s_rel) begin
            n.s_sda_lo = !r.txbuf[`TW_MSB];
            n.sshf = r.txbuf;
            n.txv = 1'b0;
            n.s_rel = 1'b1;
         end else if (r.s_rel) begin
            n.s_scl_lo = 1'b0;
            n.s_rel = 1'b0;
         end
      end

      n.sda_oe = n.m_sda_lo | n.s_sda_lo;
      n.scl_oe = n.m_scl_lo | n.s_scl_lo;
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         r <= '0;
         r.wreq <= 1'b1;
         r.div <= `TW_DIV_RST;
         r.scl_sy <= `TW_SYNC_RST;
         r.sda_sy <= `TW_SYNC_RST;
      end else begin
         r <= n;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);

   sequence s_req;
      (read || write) && r.wreq;
   endsequence
   sequence s_sta_cmd;
      wr_go && address == `TW_A_CMD && m_on && r.mst == M_IDLE && writedata[`TW_CM_STA];
   endsequence
   sequence s_adr_hit;
      s_on && !start_c && !stop_c && r.slv == S_ADR && scl_fall && r.sbit == `TW_ACK_BIT
         && r.sshf[`TW_ADR_F] == r.sadr[`TW_ADR_F];
   endsequence

   AST_BUS_ANSWER: assert property (s_req |=> !waitrequest ##1 waitrequest)
      else $error("bus answer not one wait cycle");
   AST_LINES_LOW: assert property (!sda_o && !scl_o)
      else $error("line driven high");
   AST_START_BUSY: assert property (start_c |=> r.busy && r.sta)
      else $error("start not seen");
   AST_STOP_IDLE: assert property (stop_c |=> !r.busy && r.stp)
      else $error("stop not seen");
   AST_DATA_SCL_LOW: assert property ((r.mst == M_BIT && $changed(sda_oe)) |-> scl_oe && $past(scl_oe))
      else $error("master sda moved with scl free");
   AST_START_SEQ: assert property (s_sta_cmd |=> r.mst == M_STA ##0 r.ph == 2'h0)
      else $error("start command not taken");
   AST_MSB_FIRST: assert property ((r.mst == M_BIT && !r.mrd && r.mbit != `TW_ACK_BIT && r.ph == 2'h1) |-> r.m_sda_lo == !r.mshf[`TW_MSB])
      else $error("bit order wrong");
   AST_ADDR_ACK: assert property (s_adr_hit |=> sda_oe && r.acktim)
      else $error("matching address not acked");
   AST_ACK_RELEASE: assert property ((r.mst == M_BIT && !r.mrd && r.mbit == `TW_ACK_BIT && r.ph == 2'h1) |-> !r.m_sda_lo)
      else $error("sender holds sda in ack clock");
   AST_STRETCH_WAIT: assert property ((r.mst == M_BIT && r.ph == 2'h2 && !scl_h) |=> r.ph == 2'h2 && r.mst == M_BIT)
      else $error("master ran past stretched clock");
   AST_WAIT_IDLE: assert property ((r.mst == M_STA && r.ph == 2'h0 && r.busy && !r.own) |=> r.ph == 2'h0)
      else $error("start on busy bus");
   AST_ARB_LOSS: assert property ((r.mst == M_BIT && r.ph == 2'h2 && tick && scl_h && !r.mrd && r.mbit != `TW_ACK_BIT && !r.m_sda_lo && !sda_h) |=> r.arbl && !sda_oe && !scl_oe)
      else $error("lost arbitration not withdrawn");
   AST_ARB_RELEASE: assert property ($rose(r.arbl) |-> r.mst == M_IDLE && !r.own)
      else $error("losing master kept bus");
   AST_BLIP_NOT_STOP: assert property ((r.busy && !r.scl_lo && scl_h && r.scl_sy[2] && sda_h && !r.sda_sy[2]) |=> r.busy)
      else $error("blip taken as stop");
endmodule // tw_core

//--- tb/tw_peer.sv
`timescale 1ns/1ps
// far-side slave; a released line floats high through the bus pull-up
module tw_peer
   import tw_pkg::*;
#(
   parameter logic [6:0] ADR = 7'h2A,
   parameter int STRETCH = 2000
) (
   // bus
   input wire logic scl,
   input wire logic sda,
   output logic scl_pull,
   output logic sda_pull,
   // data
   input wire logic [7:0] tx_byte,
   output logic [7:0] rx_byte
);
   logic [7:0] sh;
   logic [7:0] tsh;
   logic act, rd, adr_ph;
   int n;
   initial begin
      {scl_pull, sda_pull, act, rd, adr_ph} = 5'h00;
      n = 0;
      sh = 8'h00;
      tsh = 8'hFF;
      rx_byte = 8'h00;
   end
   always @(negedge sda) if (scl === 1'b1) begin
      n = 0;
      act = 1'b1;
      adr_ph = 1'b1;
      rd = 1'b0;
      sda_pull = 1'b0;
   end
   always @(posedge sda) if (scl === 1'b1) act = 1'b0;
   always @(posedge scl) if (act) begin
      if (n < 8) sh = {sh[6:0], sda};
      else if (rd && sda === 1'b1) act = 1'b0;
      n = n + 1;
   end
   always @(negedge scl) if (act) begin
      if (n == 8) begin
         if (adr_ph) begin
            adr_ph = 1'b0;
            rd = sh[0];
            if (sh[7:1] !== ADR) act = 1'b0;
            else sda_pull = 1'b1;
         end else begin
            if (!rd) rx_byte = sh;
            sda_pull = !rd;
         end
      end else if (n == 9) begin
         n = 0;
         tsh = tx_byte;
         sda_pull = rd && !tsh[7];
         // stretch every acked byte so the master must wait on a low clock
         scl_pull = 1'b1;
         #(STRETCH) scl_pull = 1'b0;
      end else sda_pull = rd && !tsh[7 - n];
   end
endmodule // tw_peer

//--- tb/tb_tw_core.sv
`timescale 1ns/1ps
`include "tw_cfg.svh"
module tb_tw_core
   import tw_pkg::*;
;
   logic clock = 1'b0, rstn = 1'b0, lclk = 1'b0;
   logic [4:0] address = 5'h00;
   logic read = 1'b0, write = 1'b0;
   logic [31:0] writedata = 32'h0, readdata, rv, seed = 32'h729D;
   logic waitrequest, scl_o, scl_oe, sda_o, sda_oe, p_scl, p_sda;
   logic bm_scl = 1'b0, bm_sda = 1'b0;
   logic [7:0] tx_byte = 8'h00, rx_byte, d;
   wire logic scl = !(scl_oe | p_scl | bm_scl);
   wire logic sda = !(sda_oe | p_sda | bm_sda);
   logic [31:0] eq[$], mq[$];
   int n_fail = 0, n_compared = 0, cyc = 0;
   always #20 clock = ~clock;
   always #160 lclk = ~lclk;
   tw_core DUT (.clock(clock), .rstn(rstn), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .scl_i(scl),
      .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
   tw_peer PEER (.scl(scl), .sda(sda), .scl_pull(p_scl), .sda_pull(p_sda),
      .tx_byte(tx_byte), .rx_byte(rx_byte));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic results();
      if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
      n_compared++;
      if (s !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] v);
      @(posedge clock);
      address <= a;
      writedata <= {24'h000000, v};
      write <= w;
      read <= !w;
      do @(posedge clock); while (waitrequest !== 1'b0);
      rv = readdata;
      write <= 1'b0;
      read <= 1'b0;
   endtask
   // expectations are queued before the read; the watcher pops them
   task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
      eq.push_back(e & m);
      mq.push_back(m);
      bus(1'b0, a, 8'h00);
   endtask
   always @(posedge clock) if (read && waitrequest === 1'b0) begin
      cmp("readdata", eq.pop_front(), readdata & mq.pop_front());
   end
   task automatic op(input logic [7:0] c);
      bus(1'b1, `TW_A_CMD, c);
      do rd(`TW_A_CMD, 32'h0, 32'h0); while (rv[5] !== 1'b0);
   endtask
   task automatic mwr(input logic [7:0] b, input logic nack);
      bus(1'b1, `TW_A_BUF, b);
      op(8'h04);
      rd(`TW_A_CMD, {25'h0, nack, 6'h0}, 32'h40);
   endtask
   task automatic lk_bit(input logic b, output logic s);
      @(posedge lclk) bm_sda <= !b;
      @(posedge lclk) bm_scl <= 1'b0;
      @(posedge lclk) while (scl !== 1'b1) @(posedge lclk);
      s = sda;
      bm_scl <= 1'b1;
   endtask
   task automatic lk_byte(input logic [7:0] b, input logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) lk_bit(b[i], s);
      lk_bit(1'b1, s);
      cmp("slave_ack", {31'h0, !ack}, {31'h0, s});
   endtask
   task automatic lk_frame(input logic [7:0] a, input logic [7:0] v, input logic m);
      @(posedge lclk) bm_sda <= 1'b1;
      @(posedge lclk) bm_scl <= 1'b1;
      lk_byte(a, m);
      if (m) lk_byte(v, 1'b1);
      @(posedge lclk) bm_sda <= 1'b1;
      @(posedge lclk) bm_scl <= 1'b0;
      @(posedge lclk) bm_sda <= 1'b0;
   endtask
   always @(posedge clock) begin
      cyc++;
      if (cyc == 80000) begin
         n_fail++;
         results();
      end
   end
   initial begin
      repeat (3) @(posedge clock);
      rstn <= 1'b1;
      rd(`TW_A_CON1, 32'h0, 32'hFF);
      rd(`TW_A_DIV, 32'h3E, 32'hFF);
      rd(`TW_A_STAT, 32'h0, 32'hFF);
      rd(5'h1C, 32'h0, 32'hFFFFFFFF);
      // divider 4 keeps each phase well above the input sync delay
      bus(1'b1, `TW_A_DIV, 8'h04);
      bus(1'b1, `TW_A_CON1, 8'h28);
      seed = lfsr(seed);
      d = seed[7:0];
      op(8'h01);
      mwr(8'h54, 1'b0);
      mwr(d, 1'b0);
      cmp("peer_rx", {24'h0, d}, {24'h0, rx_byte});
      seed = lfsr(seed);
      tx_byte <= seed[7:0];
      op(8'h01);
      mwr(8'h55, 1'b0);
      op(8'h18);
      rd(`TW_A_BUF, {24'h0, tx_byte}, 32'hFF);
      op(8'h02);
      op(8'h01);
      mwr(8'h7E, 1'b1);
      op(8'h02);
      bus(1'b1, `TW_A_CON1, 8'h26);
      bus(1'b1, `TW_A_SADR, 8'h62);
      seed = lfsr(seed);
      lk_frame(8'h62, seed[7:0], 1'b1);
      rd(`TW_A_STAT, 32'h21, 32'h25);
      rd(`TW_A_BUF, {24'h0, seed[7:0]}, 32'hFF);
      lk_frame(8'h64, 8'h00, 1'b0);
      cmp("line_levels", 32'h0, {30'h0, scl_o, sda_o});
      results();
   end
endmodule // tb_tw_core
